/* File: core/timer_clock_pkg.sv */
// timer clock selection: register map, field positions, divider counts
// shared by the clock-select top, its checker and its bench
package timer_clock_pkg;
  localparam logic [7:0] TIMER_CLOCK_SELECT_ADDR = 8'h8E;
  localparam logic [7:0] TIMER3_CONTROL_ADDR     = 8'h91;
  localparam logic [7:0] TIMER_CLOCK_SELECT_RST  = 8'h00;
  localparam logic [7:0] TIMER3_CONTROL_RST      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;
  // timer_clock_select_reg fields
  localparam int T3_HIGH_SEL_BIT = 7;
  localparam int T3_LOW_SEL_BIT  = 6;
  localparam int T2_HIGH_SEL_BIT = 5;
  localparam int T2_LOW_SEL_BIT  = 4;
  localparam int T1_SEL_BIT      = 3;
  localparam int T0_SEL_BIT      = 2;
  localparam int PRESCALE_LSB    = 0;
  // timer3_control_reg fields
  localparam int T3_HIGH_OVF_BIT = 7;
  localparam int T3_LOW_OVF_BIT  = 6;
  localparam int T3_CAPTURE_BIT  = 4;
  localparam int T3_SPLIT_BIT    = 3;
  localparam int T3_RUN_BIT      = 2;
  localparam int T3_ALT_LSB      = 0;
  // prescale and alternate clock codes
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4  = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT8  = 2'h3;
  localparam logic [1:0] T3ALT_DIV12_RTC  = 2'h0;
  localparam logic [1:0] T3ALT_OSC8_RTC   = 2'h1;
  localparam logic [1:0] T3ALT_DIV12_OSC8 = 2'h2;
  localparam logic [1:0] T3ALT_RTC_OSC8   = 2'h3;
  // divider counts in core clock cycles; the external divider counts oscillator rising edges
  localparam int DIV4_COUNT   = 4;
  localparam int DIV12_COUNT  = 12;
  localparam int DIV48_COUNT  = 48;
  localparam int EXT_DIV_COUNT = 8;
  localparam logic [5:0] DIV4_LAST  = 6'(DIV4_COUNT - 1);
  localparam logic [5:0] DIV12_LAST = 6'(DIV12_COUNT - 1);
  localparam logic [5:0] DIV48_LAST = 6'(DIV48_COUNT - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV_COUNT - 1);
  // synchronised sources: index into the source vector
  localparam int SRC_EXT_OSC = 0;
  localparam int SRC_RTC     = 1;
  localparam int SRC_T2_ALT  = 2;
  localparam int SRC_COUNT   = 3;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2_low;
    logic t2_high;
    logic t3_low;
    logic t3_high;
    logic t3_capture;
  } timer_ticks_t;
endpackage : timer_clock_pkg

/* File: core/clock_source_sync.sv */
// two-flop synchroniser with rising-edge pulse for one slow clock source
// assumes the source toggles slower than half the core clock
`timescale 1ns/1ps
module clock_source_sync #(
  parameter int STAGES = 2
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // source and edge pulse
  input  wire logic src_in,
  output logic      rise_out
);
  initial begin
    if (STAGES < 2) begin
      $error("clock_source_sync needs at least two stages");
    end
  end

  logic [STAGES-1:0] sync_q;
  logic              last_q;
  wire  logic        synced = sync_q[STAGES-1];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_q   <= '0;
      last_q   <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      sync_q   <= {sync_q[STAGES-2:0], src_in};
      last_q   <= synced;
      rise_out <= synced & ~last_q;
    end
  end
endmodule : clock_source_sync

/* File: core/timer_clock_select.sv */
// timer clock selection: prescaler, per-timer source select, timer 3 counter
// assumes a single-cycle special function register port on the core clock
// Operation
// - T3 high split: alternate at 0, core at 1
// - T3 low byte: alternate at 0, core at 1
// - low select clocks whole 16-bit timer 3
// - timer 2 gets same per-byte selection
// - T0/T1: prescaler at 0, core at 1
// - prescale codes: /12, /4, /48, external /8
// - T3 alternate code picks clock and capture trigger
// - timer 3 is 16-bit or two 8-bit reloads
// - run gates whole, or only high in split
// - every external source synchronised before use
`timescale 1ns/1ps
module timer_clock_select
  import timer_clock_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  // special function register port
  input  wire logic [7:0]  SFR_ADDR_IN,
  input  wire logic        SFR_WR_IN,
  input  wire logic        SFR_RD_IN,
  input  wire logic [7:0]  SFR_WDATA_IN,
  output logic [7:0]       SFR_RDATA_OUT,
  // raw clock sources
  input  wire logic        EXT_OSC_IN,
  input  wire logic        RTC_CLK_IN,
  input  wire logic        T2_ALT_CLK_IN,
  // neighbouring timer configuration
  input  wire logic        TIMER0_COUNTER_MODE_IN,
  input  wire logic        TIMER1_COUNTER_MODE_IN,
  input  wire logic        T2_SPLIT_ENABLE_IN,
  input  wire logic [15:0] T3_RELOAD_IN,
  // count enables and timer 3 state
  output timer_ticks_t     TICKS_OUT,
  output logic [7:0]       T3_LOW_COUNT_OUT,
  output logic [7:0]       T3_HIGH_COUNT_OUT
);
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("timer_clock_select needs at least two sync stages");
    end
  end

  logic [7:0]  clk_sel_q;
  logic [7:0]  t3_ctrl_q;
  logic [7:0]  t3_ctrl_d;
  logic [5:0]  div_cnt_q;
  logic [2:0]  osc_cnt_q;
  logic [15:0] t3_cnt_q;
  logic [15:0] t3_cnt_d;
  logic        t3_low_ovf;
  logic        t3_high_ovf;
  logic [SRC_COUNT-1:0] src_raw;
  logic [SRC_COUNT-1:0] src_rise;

  assign src_raw[SRC_EXT_OSC] = EXT_OSC_IN;
  assign src_raw[SRC_RTC]     = RTC_CLK_IN;
  assign src_raw[SRC_T2_ALT]  = T2_ALT_CLK_IN;

  genvar gi;
  generate
    for (gi = 0; gi < SRC_COUNT; gi++) begin : g_sync
      clock_source_sync #(.STAGES(SYNC_STAGES)) u_sync (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .src_in   (src_raw[gi]),
        .rise_out (src_rise[gi])
      );
    end
  endgenerate

  // register decode
  wire logic       wr_sel  = SFR_WR_IN && (SFR_ADDR_IN == TIMER_CLOCK_SELECT_ADDR);
  wire logic       wr_t3   = SFR_WR_IN && (SFR_ADDR_IN == TIMER3_CONTROL_ADDR);
  wire logic [7:0] rd_data = (SFR_ADDR_IN == TIMER_CLOCK_SELECT_ADDR) ? clk_sel_q :
                             (SFR_ADDR_IN == TIMER3_CONTROL_ADDR)     ? t3_ctrl_q :
                             UNMAPPED_READ;

  // field extraction
  wire logic [1:0] prescale_code = clk_sel_q[PRESCALE_LSB +: 2];
  wire logic [1:0] t3_alt_code   = t3_ctrl_q[T3_ALT_LSB +: 2];
  wire logic       t3_split      = t3_ctrl_q[T3_SPLIT_BIT];
  wire logic       t3_run        = t3_ctrl_q[T3_RUN_BIT];
  wire logic       t3_capture_en = t3_ctrl_q[T3_CAPTURE_BIT];

  // one mod-48 counter yields /4, /12 and /48 so the rates stay phase aligned
  wire logic div_wrap = (div_cnt_q == DIV48_LAST);
  wire logic div4     = (div_cnt_q[1:0] == DIV4_LAST[1:0]);
  wire logic div12    = (div_cnt_q == DIV12_LAST) ||
                        (div_cnt_q == 6'(DIV12_LAST + 6'(DIV12_COUNT))) ||
                        (div_cnt_q == 6'(DIV12_LAST + 6'(2 * DIV12_COUNT))) ||
                        div_wrap;
  wire logic osc_rise = src_rise[SRC_EXT_OSC];
  wire logic osc8     = osc_rise && (osc_cnt_q == EXT_DIV_LAST);
  wire logic rtc_rise = src_rise[SRC_RTC];

  // shared timer 0/1 prescaler
  wire logic prescale_tick = (prescale_code == PRESCALE_DIV12) ? div12 :
                             (prescale_code == PRESCALE_DIV4)  ? div4 :
                             (prescale_code == PRESCALE_DIV48) ? div_wrap :
                             osc8;

  // counter mode leaves the tick to the timer's own pin logic
  wire logic t0_tick = !TIMER0_COUNTER_MODE_IN &&
                       (clk_sel_q[T0_SEL_BIT] ? 1'b1 : prescale_tick);
  wire logic t1_tick = !TIMER1_COUNTER_MODE_IN &&
                       (clk_sel_q[T1_SEL_BIT] ? 1'b1 : prescale_tick);

  // timer 3 alternate clock and capture trigger
  wire logic t3_alt_tick = (t3_alt_code == T3ALT_OSC8_RTC) ? osc8 :
                           (t3_alt_code == T3ALT_RTC_OSC8) ? rtc_rise :
                           div12;
  wire logic t3_trig     = (t3_alt_code == T3ALT_DIV12_RTC ||
                            t3_alt_code == T3ALT_OSC8_RTC) ? rtc_rise : osc8;

  // per-byte selects; in 16-bit mode the low select drives both bytes
  wire logic t3_low_src  = clk_sel_q[T3_LOW_SEL_BIT] ? 1'b1 : t3_alt_tick;
  wire logic t3_high_src = t3_split ?
                           (clk_sel_q[T3_HIGH_SEL_BIT] ? 1'b1 : t3_alt_tick) :
                           t3_low_src;
  wire logic t2_alt_tick = src_rise[SRC_T2_ALT];
  wire logic t2_low_src  = clk_sel_q[T2_LOW_SEL_BIT] ? 1'b1 : t2_alt_tick;
  wire logic t2_high_src = T2_SPLIT_ENABLE_IN ?
                           (clk_sel_q[T2_HIGH_SEL_BIT] ? 1'b1 : t2_alt_tick) :
                           t2_low_src;

  // run gating: in split mode the low byte always counts
  wire logic t3_low_tick  = t3_low_src && (t3_split || t3_run);
  wire logic t3_high_tick = t3_high_src && t3_run;

  // timer 3 counting with auto-reload
  always_comb begin
    t3_cnt_d    = t3_cnt_q;
    t3_low_ovf  = 1'b0;
    t3_high_ovf = 1'b0;
    if (t3_split) begin
      if (t3_low_tick) begin
        t3_low_ovf    = (t3_cnt_q[7:0] == 8'hFF);
        t3_cnt_d[7:0] = t3_low_ovf ? T3_RELOAD_IN[7:0] : 8'(t3_cnt_q[7:0] + 8'h01);
      end
      if (t3_high_tick) begin
        t3_high_ovf    = (t3_cnt_q[15:8] == 8'hFF);
        t3_cnt_d[15:8] = t3_high_ovf ? T3_RELOAD_IN[15:8] : 8'(t3_cnt_q[15:8] + 8'h01);
      end
    end else if (t3_low_tick) begin
      t3_low_ovf  = (t3_cnt_q[7:0] == 8'hFF);
      t3_high_ovf = (t3_cnt_q == 16'hFFFF);
      t3_cnt_d    = t3_high_ovf ? T3_RELOAD_IN : 16'(t3_cnt_q + 16'h0001);
    end
  end

  // overflow flags: hardware set wins over a software write in the same cycle
  always_comb begin
    t3_ctrl_d = wr_t3 ? SFR_WDATA_IN : t3_ctrl_q;
    if (t3_low_ovf) begin
      t3_ctrl_d[T3_LOW_OVF_BIT] = 1'b1;
    end
    if (t3_high_ovf) begin
      t3_ctrl_d[T3_HIGH_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      clk_sel_q <= TIMER_CLOCK_SELECT_RST;
      t3_ctrl_q <= TIMER3_CONTROL_RST;
    end else begin
      if (wr_sel) begin
        clk_sel_q <= SFR_WDATA_IN;
      end
      t3_ctrl_q <= t3_ctrl_d;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      div_cnt_q <= 6'h00;
      osc_cnt_q <= 3'h0;
      t3_cnt_q  <= 16'h0000;
    end else begin
      div_cnt_q <= div_wrap ? 6'h00 : 6'(div_cnt_q + 6'h01);
      if (osc_rise) begin
        osc_cnt_q <= 3'(osc_cnt_q + 3'h1);
      end
      t3_cnt_q <= t3_cnt_d;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      SFR_RDATA_OUT     <= 8'h00;
      TICKS_OUT         <= '0;
      T3_LOW_COUNT_OUT  <= 8'h00;
      T3_HIGH_COUNT_OUT <= 8'h00;
    end else begin
      if (SFR_RD_IN) begin
        SFR_RDATA_OUT <= rd_data;
      end
      TICKS_OUT.t0         <= t0_tick;
      TICKS_OUT.t1         <= t1_tick;
      TICKS_OUT.t2_low     <= t2_low_src;
      TICKS_OUT.t2_high    <= t2_high_src;
      TICKS_OUT.t3_low     <= t3_low_tick;
      TICKS_OUT.t3_high    <= t3_high_tick;
      TICKS_OUT.t3_capture <= t3_trig && t3_capture_en;
      T3_LOW_COUNT_OUT     <= t3_cnt_d[7:0];
      T3_HIGH_COUNT_OUT    <= t3_cnt_d[15:8];
    end
  end
endmodule : timer_clock_select

/* File: dv/timer_clock_select_assertions.sv */
// checker: tick selection and timer 3 gating seen at the top ports
// assumes control registers change only through register port writes
`timescale 1ns/1ps
module timer_clock_select_assertions
  import timer_clock_pkg::*;
(
  // clock, reset and register port
  input wire logic         CORE_CLK_IN,
  input wire logic         RST_N_IN,
  input wire logic [7:0]   SFR_ADDR_IN,
  input wire logic         SFR_WR_IN,
  input wire logic [7:0]   SFR_WDATA_IN,
  // timer configuration and results
  input wire logic         TIMER0_COUNTER_MODE_IN,
  input wire logic         TIMER1_COUNTER_MODE_IN,
  input wire timer_ticks_t TICKS_OUT,
  input wire logic [7:0]   T3_HIGH_COUNT_OUT
);
  logic [7:0] sel_q;
  logic [7:0] ctl_q;
  logic [2:0] age_q;
  // shadow copies lag pipeline, so judge only once settled
  wire        ok = (age_q == 3'h4);
  wire        cm0 = TIMER0_COUNTER_MODE_IN;
  wire        cm1 = TIMER1_COUNTER_MODE_IN;
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN || SFR_WR_IN) age_q <= 3'h0;
    else if (!ok) age_q <= age_q + 3'h1;
    if (!RST_N_IN) begin
      sel_q <= 8'h00;
      ctl_q <= 8'h00;
    end else if (SFR_WR_IN && SFR_ADDR_IN == TIMER_CLOCK_SELECT_ADDR) begin
      sel_q <= SFR_WDATA_IN;
    end else if (SFR_WR_IN && SFR_ADDR_IN == TIMER3_CONTROL_ADDR) begin
      ctl_q <= SFR_WDATA_IN;
    end
  end
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_t0_core; ok && sel_q[2] && !cm0 && !$past(cm0) |-> TICKS_OUT.t0; endproperty
  a_t0_core: assert property (p_t0_core) else $error("t0 tick missing");
  property p_t0_cm; cm0 && $past(cm0) && $past(cm0, 2) |-> !TICKS_OUT.t0; endproperty
  a_t0_cm: assert property (p_t0_cm) else $error("t0 tick in counter mode");
  property p_t1_core; ok && sel_q[3] && !cm1 && !$past(cm1) |-> TICKS_OUT.t1; endproperty
  a_t1_core: assert property (p_t1_core) else $error("t1 tick missing");
  // low byte needs run in 16-bit mode, counts regardless of run when split
  property p_t3_low; ok && sel_q[6] && (ctl_q[3] || ctl_q[2]) |-> TICKS_OUT.t3_low; endproperty
  a_t3_low: assert property (p_t3_low) else $error("t3 low tick missing");
  property p_t3_pair; ok && !ctl_q[3] |-> TICKS_OUT.t3_high == TICKS_OUT.t3_low; endproperty
  a_t3_pair: assert property (p_t3_pair) else $error("t3 bytes split in 16-bit");
  property p_t3_high; ok && ctl_q[3] && ctl_q[2] && sel_q[7] |-> TICKS_OUT.t3_high; endproperty
  a_t3_high: assert property (p_t3_high) else $error("t3 high tick missing");
  property p_t2_low; ok && sel_q[4] |-> TICKS_OUT.t2_low; endproperty
  a_t2_low: assert property (p_t2_low) else $error("t2 low tick missing");
  property p_div4;
    disable iff (!RST_N_IN || SFR_WR_IN)
    ok && sel_q[2:0] == 3'h1 && !cm0 && TICKS_OUT.t0 |=> !TICKS_OUT.t0 [*3] ##1 TICKS_OUT.t0;
  endproperty
  a_div4: assert property (p_div4) else $error("prescale by 4 period wrong");
  property p_run; ok && !ctl_q[2] |=> $stable(T3_HIGH_COUNT_OUT); endproperty
  a_run: assert property (p_run) else $error("t3 high counts while stopped");
  property p_cap_off; ok && !ctl_q[4] |-> !TICKS_OUT.t3_capture; endproperty
  a_cap_off: assert property (p_cap_off) else $error("capture trigger while disabled");
endmodule : timer_clock_select_assertions

bind timer_clock_select timer_clock_select_assertions u_chk (.CORE_CLK_IN, .RST_N_IN,
  .SFR_ADDR_IN, .SFR_WR_IN, .SFR_WDATA_IN, .TIMER0_COUNTER_MODE_IN, .TIMER1_COUNTER_MODE_IN,
  .TICKS_OUT, .T3_HIGH_COUNT_OUT);

/* File: dv/timer_clock_select_tb_top.sv */
// bench: selections counted over one 48-cycle window, then registers and timer 3
// assumes sources toggle at fixed periods: oscillator 6, alternate 12, rtc 16
`timescale 1ns/1ps
module timer_clock_select_tb_top
  import timer_clock_pkg::*;
;
  typedef struct {logic [7:0] sel; logic [7:0] ctl; logic [1:0] cm; logic sp2; int e[6];} row_t;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ext = 1'b0, rtc = 1'b0, alt = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, lo, hi, v;
  logic [1:0] cm = 2'h0;
  logic sp2 = 1'b0;
  logic [15:0] reload = 16'hF0F0;
  logic [7:0] t3l, t3h;
  timer_ticks_t ticks;
  int errors = 0, compares = 0, ph = 0, n[6];
  row_t rows[8];
  // control value above, expected capture triggers per 48 cycles below
  logic [15:0] cap[4] = '{16'h1003, 16'h1103, 16'h1201, 16'h0300};
  wire [5:0] tk = {ticks.t0, ticks.t1, ticks.t2_low, ticks.t2_high, ticks.t3_low, ticks.t3_high};

  timer_clock_select dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SFR_ADDR_IN(addr),
    .SFR_WR_IN(wr), .SFR_RD_IN(rd), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata),
    .EXT_OSC_IN(ext), .RTC_CLK_IN(rtc), .T2_ALT_CLK_IN(alt), .TIMER0_COUNTER_MODE_IN(cm[0]),
    .TIMER1_COUNTER_MODE_IN(cm[1]), .T2_SPLIT_ENABLE_IN(sp2), .T3_RELOAD_IN(reload),
    .TICKS_OUT(ticks), .T3_LOW_COUNT_OUT(t3l), .T3_HIGH_COUNT_OUT(t3h));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    ph <= ph + 1;
    ext <= (ph % 6) < 3;
    alt <= (ph % 12) < 6;
    rtc <= (ph % 16) < 8;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask : sfr_rd
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    rows = '{'{8'h00, 8'h04, 2'h0, 1'b0, '{4, 4, 4, 4, 4, 4}},
             '{8'h01, 8'h05, 2'h0, 1'b0, '{12, 12, 4, 4, 1, 1}},
             '{8'h02, 8'h07, 2'h0, 1'b0, '{1, 1, 4, 4, 3, 3}},
             '{8'h03, 8'h06, 2'h0, 1'b0, '{1, 1, 4, 4, 4, 4}},
             '{8'hFC, 8'h04, 2'h1, 1'b0, '{0, 48, 48, 48, 48, 48}},
             '{8'h50, 8'h0C, 2'h0, 1'b1, '{4, 4, 48, 4, 48, 4}},
             '{8'hA0, 8'h0C, 2'h0, 1'b1, '{4, 4, 4, 48, 4, 48}},
             '{8'h80, 8'h04, 2'h2, 1'b0, '{4, 0, 4, 4, 4, 4}}};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sfr_rd(TIMER_CLOCK_SELECT_ADDR, v); chk(v, TIMER_CLOCK_SELECT_RST);
    sfr_rd(TIMER3_CONTROL_ADDR, v); chk(v, TIMER3_CONTROL_RST);
    sfr_wr(8'h8F, 8'hFF);
    sfr_rd(8'h8F, v); chk(v, UNMAPPED_READ);
    sfr_rd(TIMER_CLOCK_SELECT_ADDR, v); chk(v, 8'h00);
    foreach (rows[i]) begin
      @(posedge clk);
      cm <= rows[i].cm;
      sp2 <= rows[i].sp2;
      sfr_wr(TIMER_CLOCK_SELECT_ADDR, rows[i].sel);
      sfr_wr(TIMER3_CONTROL_ADDR, rows[i].ctl);
      repeat (8) @(posedge clk);
      n = '{default: 0};
      repeat (48) begin
        @(negedge clk);
        foreach (n[j]) n[j] += int'(tk[5 - j] === 1'b1);
      end
      foreach (n[j]) chk(16'(n[j]), 16'(rows[i].e[j]));
      sfr_rd(TIMER_CLOCK_SELECT_ADDR, v); chk(v, rows[i].sel);
    end
    @(posedge clk);
    cm <= 2'h0;
    // split with run off: low byte keeps counting, high byte frozen
    sfr_wr(TIMER_CLOCK_SELECT_ADDR, 8'hC0);
    sfr_wr(TIMER3_CONTROL_ADDR, 8'h08);
    repeat (4) @(posedge clk);
    @(negedge clk);
    hi = t3h;
    lo = t3l;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(t3h, hi);
    chk(16'(t3l !== lo), 16'h1);
    // 16-bit with run off: low byte checked frozen
    sfr_wr(TIMER3_CONTROL_ADDR, 8'h00);
    repeat (4) @(posedge clk);
    @(negedge clk);
    lo = t3l;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(t3l, lo);
    // split and running: each byte wraps into its own reload and flags it
    sfr_wr(TIMER3_CONTROL_ADDR, 8'h0C);
    repeat (600) @(posedge clk);
    @(negedge clk);
    chk(16'(t3l >= 8'hF0), 16'h1);
    chk(16'(t3h >= 8'hF0), 16'h1);
    sfr_rd(TIMER3_CONTROL_ADDR, v); chk(v, 8'hCC);
    // capture trigger: rtc for codes 00/01, oscillator /8 for 10/11, gated by enable
    foreach (cap[k]) begin
      sfr_wr(TIMER3_CONTROL_ADDR, cap[k][15:8]);
      repeat (8) @(posedge clk);
      n[0] = 0;
      repeat (48) begin
        @(negedge clk);
        n[0] += int'(ticks.t3_capture === 1'b1);
      end
      chk(16'(n[0]), 16'(cap[k][7:0]));
    end
    // mid-run reset: outputs clear while held, registers back at reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(16'(ticks), 16'h0000);
    chk({t3h, t3l}, 16'h0000);
    chk(16'(rdata), 16'h0000);
    @(posedge clk);
    rst_n <= 1'b1;
    sfr_rd(TIMER_CLOCK_SELECT_ADDR, v); chk(v, TIMER_CLOCK_SELECT_RST);
    sfr_rd(TIMER3_CONTROL_ADDR, v); chk(v, TIMER3_CONTROL_RST);
    conclude();
  end
endmodule : timer_clock_select_tb_top
